// File: stage_enable.sv
// Power stage enable source, stop behaviour, settings and temperature trip
`timescale 1ns/1ps
`default_nettype none
module stage_enable
    import stage_enable_pkg::*;
(
    input wire logic clk_sys, // 25 MHz system clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic hw_enable_input, // Controller enable pin, asynchronous
    input wire logic param_enable, // Enable request from parameter interface
    input wire logic can_enable, // Enable request from CAN
    input wire logic bus_enable, // Enable request from other fieldbus
    input wire logic eth_enable, // Enable request from Ethernet fieldbus
    input wire logic bus_activate, // One-cycle pulse: a fieldbus was activated
    input wire logic [1:0] bus_active_sel, // Which fieldbus bus_activate refers to
    input wire logic precharge_done, // Precharge bypassed, asynchronous
    input wire logic torque_mode, // 1: torque control, 0: position or speed
    input wire logic [15:0] speed_abs_rpm, // Absolute motor speed in rpm
    input wire logic brake_applied, // Holding brake reports engaged
    input wire logic signed [15:0] temp_sensor, // Heatsink temperature, deg C
    input wire logic signed [15:0] temp_limit, // Per-device fixed limit, deg C
    input wire logic reg_wr, // Parameter write strobe
    input wire logic reg_rd, // Parameter read strobe
    input wire logic [7:0] reg_addr, // Parameter sub-index
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data, registered
    output logic reg_ack, // Access done, one cycle
    output logic reg_err, // Access rejected or unmapped, one cycle
    output logic power_switches_on, // Output stage enable
    output logic ramp_stop, // Request braking ramp
    output logic brake_engage, // Command holding brake
    output logic half_rate, // PWM at half standard rate
    output logic overmod_on, // Enhanced sine modulation active
    output logic temp_error // Over-temperature error, sticky until reset
);
    import stage_enable_pkg::*;

    logic [2:0] hw_sync_q; // Three-stage synchroniser for enable pin
    logic [2:0] pre_sync_q; // Three-stage synchroniser for precharge
    logic hw_en_q; // Filtered enable pin
    logic pre_ok_q; // Filtered precharge state
    logic [15:0] src_q; // Enable source select
    logic [15:0] rate_q; // Switching rate select
    // Saved overmodulation select; kept over reset so a reset can apply it
    logic [15:0] overmod_q = OVERMOD_RESET;
    logic overmod_act_q; // Overmodulation value latched at reset
    logic boot_q; // Low for first cycle after reset
    logic temp_err_q; // Over-temperature latch
    logic req_en; // Combined enable request
    logic stage_on; // Stage currently conducting
    logic over_temp; // Reading above limit
    stage_state_t state_q;
    stage_state_t state_d;

    // Synchronise pins; a change is taken only when stages 2 and 3 agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hw_sync_q <= 3'h0;
            pre_sync_q <= 3'h0;
            hw_en_q <= 1'b0;
            pre_ok_q <= 1'b0;
        end else begin
            hw_sync_q <= {hw_sync_q[1:0], hw_enable_input};
            pre_sync_q <= {pre_sync_q[1:0], precharge_done};
            if (hw_sync_q[1] == hw_sync_q[2]) begin
                hw_en_q <= hw_sync_q[2];
            end
            if (pre_sync_q[1] == pre_sync_q[2]) begin
                pre_ok_q <= pre_sync_q[2];
            end
        end
    end

    // Decode the source field; unknown codes never enable, the safe choice
    always_comb begin
        case (src_q)
            SRC_INPUT_ONLY: req_en = hw_en_q;
            SRC_INPUT_PARAM: req_en = hw_en_q & param_enable;
            SRC_INPUT_CAN: req_en = hw_en_q & can_enable;
            SRC_INPUT_BUS: req_en = hw_en_q & bus_enable;
            SRC_INPUT_ETH: req_en = hw_en_q & eth_enable;
            SRC_PARAM_ONLY: req_en = param_enable;
            SRC_CAN_ONLY: req_en = can_enable;
            SRC_BUS_ONLY: req_en = bus_enable;
            SRC_ETH_ONLY: req_en = eth_enable;
            default: req_en = 1'b0;
        endcase
    end

    assign over_temp = temp_sensor > temp_limit;
    assign stage_on = (state_q != ST_OFF);

    // Over-temperature latch; cleared only by reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            temp_err_q <= 1'b0;
        end else if (over_temp) begin
            temp_err_q <= 1'b1;
        end
    end

    // Stage sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                // Precharge must be bypassed and no thermal fault pending
                if (req_en && pre_ok_q && !temp_err_q && !over_temp) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (over_temp || !pre_ok_q) begin
                    state_d = ST_OFF;
                end else if (!req_en) begin
                    state_d = torque_mode ? ST_OFF : ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (over_temp) begin
                    state_d = ST_OFF;
                end else if (speed_abs_rpm < STOP_SPEED_RPM) begin
                    state_d = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                // Off once the brake confirms it holds, or at once on over-temperature
                if (over_temp || brake_applied) begin
                    state_d = ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Stage outputs; brake engaged whenever the stage is not driving
    assign power_switches_on = stage_on;
    assign ramp_stop = (state_q == ST_RAMP);
    assign brake_engage = (state_q == ST_OFF) || (state_q == ST_BRAKE);
    assign temp_error = temp_err_q;

    // Configuration registers; stage-off-only fields refuse writes while on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            src_q <= ENABLE_SOURCE_RESET;
            rate_q <= SWITCH_RATE_RESET;
        end else begin
            if (bus_activate) begin
                // Activation beats a same-cycle write so the safe code lands
                case (bus_active_sel)
                    BUS_CAN: src_q <= SRC_INPUT_CAN;
                    BUS_OTHER: src_q <= SRC_INPUT_BUS;
                    BUS_ETH: src_q <= SRC_INPUT_ETH;
                    default: src_q <= SRC_INPUT_ETH;
                endcase
            end else if (reg_wr && reg_addr == ADDR_ENABLE_SOURCE) begin
                src_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADDR_SWITCH_RATE && !stage_on) begin
                rate_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADDR_OVERMOD && !stage_on) begin
                overmod_q <= reg_wdata;
            end
        end
    end

    // Overmodulation sampled one cycle after reset release only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boot_q <= 1'b0;
            overmod_act_q <= 1'b0;
        end else begin
            boot_q <= 1'b1;
            if (!boot_q) begin
                overmod_act_q <= overmod_q[0];
            end
        end
    end

    assign half_rate = rate_q[0];
    assign overmod_on = overmod_act_q;

    // Register read port and access answers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
            reg_err <= 1'b0;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_ENABLE_SOURCE: reg_rdata <= src_q;
                    ADDR_SWITCH_RATE: reg_rdata <= rate_q;
                    ADDR_OVERMOD: reg_rdata <= overmod_q;
                    ADDR_TEMP_READING: reg_rdata <= temp_sensor;
                    ADDR_TEMP_LIMIT: reg_rdata <= temp_limit;
                    default: begin
                        reg_rdata <= 16'h0000;
                        reg_err <= 1'b1;
                    end
                endcase
            end else if (reg_wr) begin
                case (reg_addr)
                    ADDR_ENABLE_SOURCE: reg_err <= 1'b0;
                    ADDR_SWITCH_RATE: reg_err <= stage_on;
                    ADDR_OVERMOD: reg_err <= stage_on;
                    default: reg_err <= 1'b1;
                endcase
            end
        end
    end

    a_trip_on_heat: assert property (@(posedge clk_sys) disable iff (!rst_n)
        over_temp |=> !power_switches_on) else $error("stage on over temperature");
    a_precharge_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !$past(power_switches_on) && power_switches_on |-> $past(pre_ok_q))
        else $error("enabled without precharge");
    a_torque_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ON) && torque_mode && !req_en |=> !power_switches_on && brake_engage)
        else $error("torque stop not immediate");
    a_ramp_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ON) && !torque_mode && !req_en && !over_temp && pre_ok_q
        |=> ramp_stop && power_switches_on) else $error("no ramp on disable");
    a_off_needs_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(ramp_stop) && !power_switches_on |-> $past(over_temp))
        else $error("off during ramp");
    a_rate_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        power_switches_on |=> $stable(rate_q)) else $error("rate changed while on");
    a_overmod_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        power_switches_on |=> $stable(overmod_q)) else $error("overmod changed while on");
    a_hw_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ON) && (src_q < SRC_PARAM_ONLY) && !hw_en_q |=> !(state_q == ST_ON))
        else $error("hw enable ignored");
    a_bus_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_activate && bus_active_sel == BUS_CAN |=> src_q == SRC_INPUT_CAN)
        else $error("source not loaded");
endmodule
`default_nettype wire

// File: stage_enable_pkg.sv
// Constants and types for the power stage enable and protection block
package stage_enable_pkg;
    // Object sub-indices used as register addresses on the parameter port
    localparam logic [7:0] ADDR_ENABLE_SOURCE = 8'h10;
    localparam logic [7:0] ADDR_SWITCH_RATE = 8'h30;
    localparam logic [7:0] ADDR_TEMP_READING = 8'h31;
    localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h32;
    localparam logic [7:0] ADDR_OVERMOD = 8'h3a;
    // Enable source codes
    localparam logic [15:0] SRC_INPUT_ONLY = 16'h0000;
    localparam logic [15:0] SRC_INPUT_PARAM = 16'h0001;
    localparam logic [15:0] SRC_INPUT_CAN = 16'h0002;
    localparam logic [15:0] SRC_INPUT_BUS = 16'h0003;
    localparam logic [15:0] SRC_INPUT_ETH = 16'h0008;
    localparam logic [15:0] SRC_PARAM_ONLY = 16'h0011;
    localparam logic [15:0] SRC_CAN_ONLY = 16'h0012;
    localparam logic [15:0] SRC_BUS_ONLY = 16'h0013;
    localparam logic [15:0] SRC_ETH_ONLY = 16'h0018;
    // Reset values
    localparam logic [15:0] ENABLE_SOURCE_RESET = 16'h0000;
    localparam logic [15:0] SWITCH_RATE_RESET = 16'h0000;
    localparam logic [15:0] OVERMOD_RESET = 16'h0000;
    // Stop threshold, rpm
    localparam logic [15:0] STOP_SPEED_RPM = 16'h000a;
    // Fieldbus selector codes on bus_active_sel
    localparam logic [1:0] BUS_CAN = 2'h0;
    localparam logic [1:0] BUS_OTHER = 2'h1;
    localparam logic [1:0] BUS_ETH = 2'h2;
    // Stage states
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_ON = 4'b0010,
        ST_RAMP = 4'b0100,
        ST_BRAKE = 4'b1000
    } stage_state_t;
endpackage

// File: stage_model.sv
// Power stage and holding brake model for the enable block bench
`timescale 1ns/1ps
`default_nettype none
module stage_model (
    input wire logic clk_sys, // System clock
    input wire logic stage_on, // Output stage enabled
    input wire logic ramp, // Braking ramp requested
    input wire logic brake_cmd, // Brake commanded
    output logic [15:0] speed, // Motor speed in rpm
    output logic brake_held // Brake reports engaged
);
    logic [1:0] lag_q = 2'h0; // Brake needs a few cycles to bite
    logic [15:0] speed_q = 16'h0000; // Motor at rest at start
    logic held_q = 1'b1; // Brake holds at start
    assign speed = speed_q;
    assign brake_held = held_q;
    // Slow by 7 rpm a cycle on the ramp so speed reaches 6, just under the stop limit, then 0 on the last ramp edge
    // While the brake is commanded the motor keeps its low speed
    always @(posedge clk_sys) begin
        if (ramp) begin
            speed_q <= (speed_q > 16'h0007) ? speed_q - 16'h0007 : 16'h0000;
        end else if (stage_on && !brake_cmd) begin
            speed_q <= 16'h03e8;
        end
    end
    // Brake engages only after a delay, so a stage that drops early is seen
    always @(posedge clk_sys) begin
        if (!brake_cmd) begin
            lag_q <= 2'h0;
        end else if (lag_q != 2'h3) begin
            lag_q <= lag_q + 2'h1;
        end
        held_q <= brake_cmd && (lag_q == 2'h3);
    end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the power stage enable block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import stage_enable_pkg::*;
    logic clk_sys = 1'b0; // 25 MHz clock
    logic rst_n = 1'b0; // Reset, active low
    logic hw_enable_input = 1'b0, precharge_done = 1'b0, torque_mode = 1'b0; // Levels
    logic [3:0] req = 4'h0; // Requests: param, can, bus, eth
    logic bus_activate = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Strobes
    logic [1:0] bus_active_sel = 2'h0; // Bus that was activated
    logic [7:0] reg_addr = 8'h00; // Sub-index
    logic [15:0] reg_wdata = 16'h0000; // Write data
    logic signed [15:0] temp_sensor = 16'sh0019; // Heatsink at 25 C
    logic [15:0] reg_rdata, speed_abs_rpm, rv; // Read data, speed, captured data
    logic reg_ack, reg_err, power_switches_on, ramp_stop, brake_engage, ev; // Outputs
    logic half_rate, overmod_on, temp_error, brake_applied; // Outputs
    int fails = 0, cmp_count = 0; // Mismatches and comparisons
    logic [15:0] codes [8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0008,
        16'h0011, 16'h0012, 16'h0013, 16'h0018}; // Combined, then source alone
    logic [15:0] bus_codes [4] = '{SRC_INPUT_CAN, SRC_INPUT_BUS, SRC_INPUT_ETH, SRC_INPUT_ETH};
    always #20 clk_sys = ~clk_sys;
    // Limit fixed at 85 C, as a per-device constant would be
    stage_enable dut (.clk_sys(clk_sys), .rst_n(rst_n), .hw_enable_input(hw_enable_input),
        .param_enable(req[0]), .can_enable(req[1]), .bus_enable(req[2]), .eth_enable(req[3]),
        .bus_activate(bus_activate), .bus_active_sel(bus_active_sel),
        .precharge_done(precharge_done), .torque_mode(torque_mode),
        .speed_abs_rpm(speed_abs_rpm), .brake_applied(brake_applied),
        .temp_sensor(temp_sensor), .temp_limit(16'sh0055), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .power_switches_on(power_switches_on), .ramp_stop(ramp_stop),
        .brake_engage(brake_engage), .half_rate(half_rate), .overmod_on(overmod_on),
        .temp_error(temp_error));
    stage_model partner (.clk_sys(clk_sys), .stage_on(power_switches_on), .ramp(ramp_stop),
        .brake_cmd(brake_engage), .speed(speed_abs_rpm), .brake_held(brake_applied));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk1(input string name, input logic seen, input logic exp);
        chk(name, {15'h0000, seen}, {15'h0000, exp});
    endtask
    // Waits n edges, then lets that edge's updates land
    task automatic look(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One parameter access: strobe for one edge, answer seen the cycle after
    task automatic acc(input logic rd, input logic [7:0] a, input logic [15:0] wd);
        @(posedge clk_sys);
        reg_rd <= rd;
        reg_wr <= !rd;
        reg_addr <= a;
        reg_wdata <= wd;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        rv = reg_rdata;
        ev = reg_err;
        chk1("reg_ack", reg_ack, 1'b1);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset();
        look(2);
        chk1("stage", power_switches_on, 1'b0);
        acc(1'b1, ADDR_SWITCH_RATE, 16'h0000);
        chk("rate", rv, SWITCH_RATE_RESET);
        acc(1'b1, 8'h77, 16'h0000);
        chk1("unmapped", ev, 1'b1);
        acc(1'b0, ADDR_SWITCH_RATE, 16'h0001);
        chk1("half", half_rate, 1'b1);
        acc(1'b0, ADDR_OVERMOD, 16'h0001);
        chk1("ovm_live", overmod_on, 1'b0);
        acc(1'b1, ADDR_OVERMOD, 16'h0000);
        chk("ovm_rd", rv, 16'h0001);
        acc(1'b0, ADDR_SWITCH_RATE, 16'h0000);
        chk1("std", half_rate, 1'b0);
        hw_enable_input <= 1'b1;
        look(10);
        chk1("no_pre", power_switches_on, 1'b0);
        precharge_done <= 1'b1;
        look(8);
        chk1("on", power_switches_on, 1'b1);
        acc(1'b0, ADDR_SWITCH_RATE, 16'h0001);
        chk1("rate_err", ev, 1'b1);
        chk1("rate_kept", half_rate, 1'b0);
        acc(1'b0, ADDR_OVERMOD, 16'h0000);
        acc(1'b1, ADDR_OVERMOD, 16'h0000);
        chk("ovm_kept", rv, 16'h0001);
        // Speed mode: ramp first, off once slow and braked
        hw_enable_input <= 1'b0;
        look(100);
        chk1("ramp", ramp_stop, 1'b1);
        chk1("ramp_on", power_switches_on, 1'b1);
        look(60);
        chk1("ramp_off", power_switches_on, 1'b0);
        torque_mode <= 1'b1;
        hw_enable_input <= 1'b1;
        look(8);
        chk1("tq_on", power_switches_on, 1'b1);
        hw_enable_input <= 1'b0;
        look(7);
        chk1("tq_off", power_switches_on, 1'b0);
        chk1("tq_brake", brake_engage, 1'b1);
        for (int i = 0; i < 4; i++) begin
            bus_activate <= 1'b1;
            bus_active_sel <= 2'(i);
            look(1);
            bus_activate <= 1'b0;
            acc(1'b1, ADDR_ENABLE_SOURCE, 16'h0000);
            chk("bus_code", rv, bus_codes[i]);
        end
        // Every code but SRC_INPUT_ONLY with the pin low (only lone sources enable), then with it high
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, ADDR_ENABLE_SOURCE, codes[i]);
            req <= 4'h1 << (i % 4);
            look(8);
            chk1("src", power_switches_on, i >= 4);
            hw_enable_input <= 1'b1;
            look(8);
            chk1("src_pin", power_switches_on, 1'b1);
            req <= 4'h0;
            hw_enable_input <= 1'b0;
            look(8);
        end
        acc(1'b0, ADDR_ENABLE_SOURCE, SRC_PARAM_ONLY);
        req <= 4'h1;
        acc(1'b1, ADDR_TEMP_READING, 16'h0000);
        chk("temp", rv, 16'h0019);
        acc(1'b1, ADDR_TEMP_LIMIT, 16'h0000);
        chk("limit", rv, 16'h0055);
        temp_sensor <= 16'sh0055;
        look(6);
        chk1("at_limit", power_switches_on, 1'b1);
        temp_sensor <= 16'sh0056;
        look(3);
        chk1("trip", power_switches_on, 1'b0);
        chk1("trip_err", temp_error, 1'b1);
        temp_sensor <= 16'sh0019;
        look(8);
        chk1("stays_off", power_switches_on, 1'b0);
        // The overmodulation write stands as the saved set; the reset applies it
        do_reset();
        look(3);
        chk1("ovm_after", overmod_on, 1'b1);
        chk1("err_clr", temp_error, 1'b0);
        acc(1'b1, ADDR_OVERMOD, 16'h0000);
        chk("ovm_saved", rv, 16'h0001);
        conclude();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
